/* shared/sm_rx_pkg.sv */
package sm_rx_pkg;
    // register bus: word index = byte address / 4
    localparam int IDX_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] IDX_PERIPHERAL_INT_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_PERIPHERAL_INT_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
    localparam logic [7:0] IDX_RECEIVE_DATA_FIFO = 8'h1a;
    localparam logic [7:0] IDX_SERIAL_MODE = 8'h98;
    localparam logic [7:0] IDX_BAUD_RATE_GENERATOR = 8'h99;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h40;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h41;

    // field positions
    localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
    localparam int PERIPHERAL_INTERRUPT_ENABLE_BIT = 6;
    localparam int RECEIVE_INTERRUPT_FLAG_BIT = 5;
    localparam int RECEIVE_INTERRUPT_ENABLE_BIT = 5;
    localparam int SERIAL_PORT_ENABLE_BIT = 7;
    localparam int NINTH_BIT_RECEIVE_ENABLE_BIT = 6;
    localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int OVERRUN_ERROR_BIT = 1;
    localparam int RECEIVED_NINTH_BIT_POS = 0;
    localparam int MASTER_CLOCK_SOURCE_SELECT_BIT = 7;
    localparam int SYNC_BIT = 4;
    localparam int EV_WORD_BIT = 0;
    localparam int EV_OVERRUN_BIT = 1;
    localparam int EV_W = 2;

    // word format and storage
    localparam int WORD_W = 9;
    localparam int FIFO_DEPTH = 2;
    localparam logic [3:0] SHORT_WORD_BITS = 4'h8;
    localparam logic [3:0] LONG_WORD_BITS = 4'h9;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BRG_RESET = 8'h00;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_LOW = 2'b01,
        LINK_HIGH = 2'b10
    } link_state_type;
endpackage : sm_rx_pkg

/* shared/rx_fifo_if.sv */
`timescale 1ns/1ps
interface rx_fifo_if #(parameter int WIDTH = 9);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic full;
    logic pop;
    logic [WIDTH-1:0] head;
    logic empty;
    modport owner(input push, input push_data, input pop, output full, output head, output empty);
    modport user(output push, output push_data, output pop, input full, input head, input empty);
endinterface : rx_fifo_if

/* hw/sync_two_ff.sv */
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type st;
    sync_state_type next_st;

    // first stage feeds only the second
    always_comb begin
        next_st.first = async_in;
        next_st.second = st.first;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.second;
endmodule : sync_two_ff

/* hw/rx_fifo.sv */
`timescale 1ns/1ps
module rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    rx_fifo_if.owner port
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W-1:0] wr_ptr;
        logic [CNT_W-1:0] count;
    } fifo_state_type;

    fifo_state_type st;
    fifo_state_type next_st;
    logic do_push;
    logic do_pop;

    always_comb begin
        next_st = st;
        do_push = port.push && (st.count != CNT_FULL);
        do_pop = port.pop && (st.count != '0);
        if (do_push) begin
            next_st.mem[st.wr_ptr] = port.push_data;
            next_st.wr_ptr = (st.wr_ptr == PTR_LAST) ? '0 : PTR_W'(st.wr_ptr + 1'b1);
        end
        if (do_pop) begin
            next_st.rd_ptr = (st.rd_ptr == PTR_LAST) ? '0 : PTR_W'(st.rd_ptr + 1'b1);
        end
        if (do_push && !do_pop) begin
            next_st.count = CNT_W'(st.count + 1'b1);
        end else if (do_pop && !do_push) begin
            next_st.count = CNT_W'(st.count - 1'b1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.full = (st.count == CNT_FULL);
    assign port.empty = (st.count == '0);
    assign port.head = st.mem[st.rd_ptr];
endmodule : rx_fifo

/* hw/sync_master_serial_receive.sv */
// Behaviour
// - serial port enable, sync mode, master clock select plus single/continuous bit enables reception
// - data line sampled on shift clock falling edge
// - single-receive takes one word then stops
// - continuous-receive runs until software clears it
// - both set behaves as continuous reception
// - last bit moves shift register into FIFO
// - completed move sets receive interrupt flag
// - receive interrupt request only with receive enable set
// - flag read-only, clears when FIFO drained
// - two-entry FIFO, third word keeps shifting
// - full FIFO at third word sets overrun
// - overrun blocks all moves into FIFO
// - ninth bit buffered with word; read status first
`timescale 1ns/1ps
module sync_master_serial_receive #(
    parameter int WORD_W = sm_rx_pkg::WORD_W,
    parameter int FIFO_DEPTH = sm_rx_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sm_rx_pkg::IDX_W+1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [sm_rx_pkg::DATA_W-1:0] wb_dat_i,
    output logic [sm_rx_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    output logic serial_clock_o,
    output logic serial_clock_oe,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe
);
    typedef struct packed {
        logic global_interrupt_enable;
        logic peripheral_interrupt_enable;
        logic [7:0] int_enables;
        logic serial_port_enable;
        logic ninth_bit_receive_enable;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic overrun_error;
        logic master_clock_source_select;
        logic sync_mode;
        logic [7:0] brg;
        logic [sm_rx_pkg::EV_W-1:0] ev_status;
        logic [sm_rx_pkg::EV_W-1:0] ev_mask;
        sm_rx_pkg::link_state_type link;
        logic [7:0] div;
        logic [3:0] nbits;
        logic [WORD_W-1:0] shreg;
        logic sclk;
        logic sclk_oe;
        logic data_drive;
        logic ack;
        logic [sm_rx_pkg::DATA_W-1:0] rdata;
        logic irq;
    } state_type;

    state_type st;
    state_type next_st;

    logic data_sync;
    logic wb_req;
    logic wr;
    logic rd;
    logic [sm_rx_pkg::IDX_W-1:0] idx;
    logic rx_on;
    logic [3:0] word_bits;
    logic [WORD_W-1:0] shifted;
    logic [WORD_W-1:0] word;
    logic receive_interrupt_flag;
    logic [sm_rx_pkg::EV_W-1:0] ev_set;
    logic [sm_rx_pkg::EV_W-1:0] ev_clr;

    rx_fifo_if #(.WIDTH(WORD_W)) fifo ();

    rx_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .port(fifo.owner)
    );

    sync_two_ff #(
        .WIDTH(1)
    ) u_data_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(serial_data_i),
        .sync_out(data_sync)
    );

    always_comb begin
        next_st = st;
        fifo.push = 1'b0;
        fifo.push_data = '0;
        fifo.pop = 1'b0;
        ev_set = '0;
        ev_clr = '0;
        word = '0;
        shifted = {data_sync, st.shreg[WORD_W-1:1]};
        idx = wb_adr_i[sm_rx_pkg::IDX_W+1:2];
        wb_req = wb_cyc_i && wb_stb_i && !st.ack;
        wr = wb_req && wb_we_i && wb_sel_i[0];
        rd = wb_req && !wb_we_i;
        receive_interrupt_flag = !fifo.empty;
        next_st.ack = wb_req;

        // register reads; unmapped words read zero
        if (rd) begin
            next_st.rdata = '0;
            case (idx)
                sm_rx_pkg::IDX_INTERRUPT_CONTROL: begin
                    next_st.rdata[sm_rx_pkg::GLOBAL_INTERRUPT_ENABLE_BIT] = st.global_interrupt_enable;
                    next_st.rdata[sm_rx_pkg::PERIPHERAL_INTERRUPT_ENABLE_BIT] = st.peripheral_interrupt_enable;
                end
                sm_rx_pkg::IDX_PERIPHERAL_INT_FLAGS: begin
                    next_st.rdata[sm_rx_pkg::RECEIVE_INTERRUPT_FLAG_BIT] = receive_interrupt_flag;
                end
                sm_rx_pkg::IDX_PERIPHERAL_INT_ENABLES: begin
                    next_st.rdata[7:0] = st.int_enables;
                end
                sm_rx_pkg::IDX_RECEIVE_STATUS_CONTROL: begin
                    next_st.rdata[sm_rx_pkg::SERIAL_PORT_ENABLE_BIT] = st.serial_port_enable;
                    next_st.rdata[sm_rx_pkg::NINTH_BIT_RECEIVE_ENABLE_BIT] = st.ninth_bit_receive_enable;
                    next_st.rdata[sm_rx_pkg::SINGLE_RECEIVE_ENABLE_BIT] = st.single_receive_enable;
                    next_st.rdata[sm_rx_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT] = st.continuous_receive_enable;
                    next_st.rdata[sm_rx_pkg::OVERRUN_ERROR_BIT] = st.overrun_error;
                    // ninth bit of the word at the FIFO head
                    next_st.rdata[sm_rx_pkg::RECEIVED_NINTH_BIT_POS] = receive_interrupt_flag
                        && fifo.head[WORD_W-1];
                end
                sm_rx_pkg::IDX_RECEIVE_DATA_FIFO: begin
                    next_st.rdata[7:0] = fifo.head[7:0];
                    fifo.pop = receive_interrupt_flag;
                end
                sm_rx_pkg::IDX_SERIAL_MODE: begin
                    next_st.rdata[sm_rx_pkg::MASTER_CLOCK_SOURCE_SELECT_BIT] = st.master_clock_source_select;
                    next_st.rdata[sm_rx_pkg::SYNC_BIT] = st.sync_mode;
                end
                sm_rx_pkg::IDX_BAUD_RATE_GENERATOR: begin
                    next_st.rdata[7:0] = st.brg;
                end
                sm_rx_pkg::IDX_EVENT_STATUS: begin
                    next_st.rdata[sm_rx_pkg::EV_W-1:0] = st.ev_status;
                end
                sm_rx_pkg::IDX_EVENT_MASK: begin
                    next_st.rdata[sm_rx_pkg::EV_W-1:0] = st.ev_mask;
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end

        // register writes, byte lane 0 only
        if (wr) begin
            case (idx)
                sm_rx_pkg::IDX_INTERRUPT_CONTROL: begin
                    next_st.global_interrupt_enable = wb_dat_i[sm_rx_pkg::GLOBAL_INTERRUPT_ENABLE_BIT];
                    next_st.peripheral_interrupt_enable = wb_dat_i[sm_rx_pkg::PERIPHERAL_INTERRUPT_ENABLE_BIT];
                end
                sm_rx_pkg::IDX_PERIPHERAL_INT_ENABLES: begin
                    next_st.int_enables = wb_dat_i[7:0];
                end
                sm_rx_pkg::IDX_RECEIVE_STATUS_CONTROL: begin
                    next_st.serial_port_enable = wb_dat_i[sm_rx_pkg::SERIAL_PORT_ENABLE_BIT];
                    next_st.ninth_bit_receive_enable = wb_dat_i[sm_rx_pkg::NINTH_BIT_RECEIVE_ENABLE_BIT];
                    next_st.single_receive_enable = wb_dat_i[sm_rx_pkg::SINGLE_RECEIVE_ENABLE_BIT];
                    next_st.continuous_receive_enable = wb_dat_i[sm_rx_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT];
                    if (!wb_dat_i[sm_rx_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
                        next_st.overrun_error = 1'b0;
                    end
                end
                sm_rx_pkg::IDX_SERIAL_MODE: begin
                    next_st.master_clock_source_select = wb_dat_i[sm_rx_pkg::MASTER_CLOCK_SOURCE_SELECT_BIT];
                    next_st.sync_mode = wb_dat_i[sm_rx_pkg::SYNC_BIT];
                end
                sm_rx_pkg::IDX_BAUD_RATE_GENERATOR: begin
                    next_st.brg = wb_dat_i[7:0];
                end
                sm_rx_pkg::IDX_EVENT_STATUS: begin
                    ev_clr = wb_dat_i[sm_rx_pkg::EV_W-1:0];
                end
                sm_rx_pkg::IDX_EVENT_MASK: begin
                    next_st.ev_mask = wb_dat_i[sm_rx_pkg::EV_W-1:0];
                end
                default: begin
                    ev_clr = '0;
                end
            endcase
        end

        // link engine takes enables and word length from the freshly written settings; brg compare uses the registered value
        rx_on = next_st.serial_port_enable && next_st.sync_mode && next_st.master_clock_source_select
            && (next_st.single_receive_enable || next_st.continuous_receive_enable);
        word_bits = next_st.ninth_bit_receive_enable ? sm_rx_pkg::LONG_WORD_BITS : sm_rx_pkg::SHORT_WORD_BITS;
        next_st.sclk_oe = next_st.serial_port_enable && next_st.sync_mode
            && next_st.master_clock_source_select;
        next_st.data_drive = 1'b0;

        case (st.link)
            sm_rx_pkg::LINK_IDLE: begin
                next_st.sclk = 1'b0;
                next_st.div = '0;
                next_st.nbits = '0;
                if (rx_on) begin
                    next_st.link = sm_rx_pkg::LINK_LOW;
                end
            end
            sm_rx_pkg::LINK_LOW: begin
                if (!rx_on) begin
                    next_st.sclk = 1'b0;
                    next_st.link = sm_rx_pkg::LINK_IDLE;
                end else if (st.div == st.brg) begin
                    // half period of brg+1 clocks
                    next_st.div = '0;
                    next_st.sclk = 1'b1;
                    next_st.link = sm_rx_pkg::LINK_HIGH;
                end else begin
                    next_st.div = 8'(st.div + 1'b1);
                end
            end
            sm_rx_pkg::LINK_HIGH: begin
                if (!rx_on) begin
                    next_st.sclk = 1'b0;
                    next_st.link = sm_rx_pkg::LINK_IDLE;
                end else if (st.div == st.brg) begin
                    next_st.div = '0;
                    next_st.sclk = 1'b0;
                    next_st.shreg = shifted;
                    next_st.link = sm_rx_pkg::LINK_LOW;
                    if (4'(st.nbits + 1'b1) == word_bits) begin
                        next_st.nbits = '0;
                        if (next_st.ninth_bit_receive_enable) begin
                            word = shifted;
                        end else begin
                            word = {1'b0, shifted[WORD_W-1:1]};
                        end
                        if (st.overrun_error) begin
                            word = '0;
                        end else if (fifo.full) begin
                            next_st.overrun_error = 1'b1;
                            ev_set[sm_rx_pkg::EV_OVERRUN_BIT] = 1'b1;
                        end else begin
                            fifo.push = 1'b1;
                            fifo.push_data = word;
                            ev_set[sm_rx_pkg::EV_WORD_BIT] = 1'b1;
                        end
                        if (!next_st.continuous_receive_enable) begin
                            next_st.single_receive_enable = 1'b0;
                            next_st.link = sm_rx_pkg::LINK_IDLE;
                        end
                        // continuous enable wins and keeps going
                    end else begin
                        next_st.nbits = 4'(st.nbits + 1'b1);
                    end
                end else begin
                    next_st.div = 8'(st.div + 1'b1);
                end
            end
            default: begin
                next_st.link = sm_rx_pkg::LINK_IDLE;
            end
        endcase

        // sticky events: a set in the clearing cycle survives
        next_st.ev_status = (st.ev_status & ~ev_clr) | ev_set;
        next_st.irq = (st.global_interrupt_enable && st.peripheral_interrupt_enable
            && st.int_enables[sm_rx_pkg::RECEIVE_INTERRUPT_ENABLE_BIT] && receive_interrupt_flag)
            || (|(next_st.ev_status & next_st.ev_mask));
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.int_enables <= sm_rx_pkg::BYTE_RESET;
            st.brg <= sm_rx_pkg::BRG_RESET;
            st.link <= sm_rx_pkg::LINK_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign irq = st.irq;
    assign serial_clock_o = st.sclk;
    assign serial_clock_oe = st.sclk_oe;
    assign serial_data_o = st.data_drive;
    assign serial_data_oe = st.data_drive;
endmodule : sync_master_serial_receive

/* bench/sm_rx_sva.sv */
`timescale 1ns/1ps
module sm_rx_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sm_rx_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq,
    input wire logic serial_clock_o,
    input wire logic serial_clock_oe,
    input wire logic serial_data_o,
    input wire logic serial_data_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic prev_clk;
    logic [3:0] since_set;
    logic [3:0] since_acc;
    // cycles since a clock fall or a write, and since any access
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_clk <= 1'b0;
            since_set <= 4'hf;
            since_acc <= 4'hf;
        end else begin
            prev_clk <= serial_clock_o;
            if ((prev_clk && !serial_clock_o) || (wb_ack_o && wb_we_i))
                since_set <= 4'h0;
            else if (since_set != 4'hf)
                since_set <= since_set + 4'h1;
            if (wb_ack_o)
                since_acc <= 4'h0;
            else if (since_acc != 4'hf)
                since_acc <= since_acc + 4'h1;
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_one_pulse: assert property (s_req |=> s_ans)
        else $error("ack not one pulse after request");
    chk_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_rdata_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_data_released: assert property (!serial_data_oe && !serial_data_o)
        else $error("data pin driven");
    chk_clock_idle_low: assert property (!serial_clock_oe |-> !serial_clock_o)
        else $error("clock high while not driven");
    chk_clock_rise_oe: assert property ($rose(serial_clock_o) |-> serial_clock_oe)
        else $error("clock rose while not driven");
    chk_irq_rise_cause: assert property ($rose(irq) |-> since_set <= 4'h5)
        else $error("irq rose without cause");
    chk_irq_fall_cause: assert property ($fell(irq) |-> since_acc <= 4'h5)
        else $error("irq fell without access");
endmodule : sm_rx_sva
bind sync_master_serial_receive sm_rx_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .serial_clock_o(serial_clock_o), .serial_clock_oe(serial_clock_oe), .serial_data_o(serial_data_o),
    .serial_data_oe(serial_data_oe));

/* bench/sync_slave_model.sv */
`timescale 1ns/1ps
module sync_slave_model (
    input wire logic serial_clock,
    input wire logic serial_clock_oe,
    input wire logic restart,
    input wire logic nine,
    input wire logic [8:0] word,
    output logic [2:0] word_cnt,
    output logic data
);
    logic [3:0] idx;
    logic last;
    // lsb first, bit changes on the rise so it stands through the fall
    always @(posedge serial_clock or posedge restart) begin
        if (restart) begin
            idx <= 4'h0;
            word_cnt <= 3'h0;
            last <= 1'b0;
        end else begin
            last <= word[idx];
            if (idx == (nine ? 4'h8 : 4'h7)) begin
                idx <= 4'h0;
                word_cnt <= word_cnt + 3'h1;
            end else begin
                idx <= idx + 4'h1;
            end
        end
    end
    // released line shows no stale bit
    assign data = serial_clock_oe ? last : ~last;
endmodule : sync_slave_model

/* bench/sync_master_serial_receive_tb.sv */
`timescale 1ns/1ps
module sync_master_serial_receive_tb;
    localparam logic [7:0] rcs = sm_rx_pkg::IDX_RECEIVE_STATUS_CONTROL;
    localparam logic [7:0] rxd = sm_rx_pkg::IDX_RECEIVE_DATA_FIFO;
    localparam logic [7:0] pif = sm_rx_pkg::IDX_PERIPHERAL_INT_FLAGS;
    localparam logic [7:0] pie = sm_rx_pkg::IDX_PERIPHERAL_INT_ENABLES;
    localparam logic [7:0] evs = sm_rx_pkg::IDX_EVENT_STATUS;
    localparam logic [7:0] evm = sm_rx_pkg::IDX_EVENT_MASK;
    logic ref_clk = 1'b0;
    logic rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic sclk, sclk_oe, sdata, sd_o, sd_oe, pin, restart, nine;
    logic [2:0] word_cnt;
    logic [8:0] tx [8];
    logic [7:0] rd;
    logic [31:0] rng = 32'h0000f938;
    int err_count = 0, n_tests = 0, cycles = 0;

    always #12.5 ref_clk = ~ref_clk;
    assign pin = sd_oe ? sd_o : sdata;

    sync_master_serial_receive u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
        .serial_clock_o(sclk), .serial_clock_oe(sclk_oe), .serial_data_i(pin),
        .serial_data_o(sd_o), .serial_data_oe(sd_oe));
    sync_slave_model u_slave (.serial_clock(sclk), .serial_clock_oe(sclk_oe), .restart(restart),
        .nine(nine), .word(tx[word_cnt]), .word_cnt(word_cnt), .data(sdata));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    // en is serial port, ninth bit, single, continuous
    function automatic logic [7:0] stat(input logic [3:0] en, input logic ovr, input logic b9);
        return {en, 2'b00, ovr, b9};
    endfunction : stat

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check(32'(wb_ack_o), 32'h1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check({24'h0, rd}, {24'h0, exp});
    endtask : rdchk
    task automatic wait_bit(input logic [7:0] idx, input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, idx, 8'h00);
            n++;
        end while (rd[b] !== 1'b1 && n < 150);
    endtask : wait_bit
    task automatic irq_is(input logic v);
        repeat (3) @(posedge ref_clk);
        check(32'(irq), 32'(v));
    endtask : irq_is
    task automatic end_test(input string name);
        $display("test %s done, mismatches %0d", name, err_count);
        restart <= 1'b1;
        @(posedge ref_clk);
        restart <= 1'b0;
    endtask : end_test

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            check(32'h1, 32'h0);
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        restart = 1'b1;
        nine = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            tx[i] = rng[8:0];
        end
        tx[1] = 9'h100;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        restart <= 1'b0;
        @(posedge ref_clk);
        rdchk(pie, 8'h00);
        rdchk(pif, 8'h00);
        rdchk(rcs, 8'h00);
        rdchk(8'hff, 8'h00);
        bus(1'b1, sm_rx_pkg::IDX_BAUD_RATE_GENERATOR, 8'h03);
        bus(1'b1, sm_rx_pkg::IDX_SERIAL_MODE, 8'h90);
        bus(1'b1, sm_rx_pkg::IDX_INTERRUPT_CONTROL, 8'hc0);
        bus(1'b1, pie, 8'h20);
        bus(1'b1, rcs, 8'ha0);
        wait_bit(pif, 5);
        irq_is(1'b1);
        bus(1'b1, pie, 8'h00);
        irq_is(1'b0);
        bus(1'b1, evm, 8'h01);
        irq_is(1'b1);
        bus(1'b1, evs, 8'h03);
        irq_is(1'b0);
        bus(1'b1, evm, 8'h00);
        rdchk(rcs, stat(4'h8, 1'b0, 1'b0));
        rdchk(rxd, tx[0][7:0]);
        rdchk(pif, 8'h00);
        end_test("single");
        nine <= 1'b1;
        bus(1'b1, rcs, 8'hd0);
        wait_bit(rcs, 1);
        rdchk(rcs, stat(4'hd, 1'b1, tx[0][8]));
        rdchk(rxd, tx[0][7:0]);
        rdchk(rcs, stat(4'hd, 1'b1, tx[1][8]));
        rdchk(rxd, tx[1][7:0]);
        rdchk(pif, 8'h00);
        repeat (200) @(posedge ref_clk);
        rdchk(pif, 8'h00);
        rdchk(evs, 8'h03);
        bus(1'b1, rcs, 8'hc0);
        rdchk(rcs, stat(4'hc, 1'b0, 1'b0));
        nine <= 1'b0;
        end_test("overrun");
        bus(1'b1, rcs, 8'hb0);
        wait_bit(pif, 5);
        rdchk(rcs, stat(4'hb, 1'b0, 1'b0));
        rdchk(rxd, tx[0][7:0]);
        wait_bit(pif, 5);
        rdchk(rxd, tx[1][7:0]);
        bus(1'b1, rcs, 8'h80);
        end_test("continuous");
        wrap_up();
    end
endmodule : sync_master_serial_receive_tb
